// ==== hdl/scs_top.sv ====
// System clock selection: oscillator control, CPU clock mux and register slave
`default_nettype none
module scs_top
    import scs_pkg::*;
#(
    parameter int STAB_WAIT_LOG2 = STAB_LOG2
)
(
    input  wire logic                    I_CLK,
    input  wire logic                    I_RST_N,
    input  wire logic                    I_MAIN_OSC_IN,
    input  wire logic                    I_SUB_OSC_IN,
    input  wire logic                    I_STOP_MODE,
    input  wire logic [AXI_ADDR_W-1:0]   I_S_AXI_AWADDR,
    input  wire logic                    I_S_AXI_AWVALID,
    output var  logic                    O_S_AXI_AWREADY,
    input  wire logic [AXI_DATA_W-1:0]   I_S_AXI_WDATA,
    input  wire logic [AXI_DATA_W/8-1:0] I_S_AXI_WSTRB,
    input  wire logic                    I_S_AXI_WVALID,
    output var  logic                    O_S_AXI_WREADY,
    output var  logic [1:0]              O_S_AXI_BRESP,
    output var  logic                    O_S_AXI_BVALID,
    input  wire logic                    I_S_AXI_BREADY,
    input  wire logic [AXI_ADDR_W-1:0]   I_S_AXI_ARADDR,
    input  wire logic                    I_S_AXI_ARVALID,
    output var  logic                    O_S_AXI_ARREADY,
    output var  logic [AXI_DATA_W-1:0]   O_S_AXI_RDATA,
    output var  logic [1:0]              O_S_AXI_RRESP,
    output var  logic                    O_S_AXI_RVALID,
    input  wire logic                    I_S_AXI_RREADY,
    output var  logic                    O_MAIN_OSC_EN,
    output var  logic                    O_MAIN_IN_GROUND,
    output var  logic                    O_SUB_FEEDBACK_CUT,
    output var  logic                    O_SUB_LOW_DRIVE,
    output var  logic                    O_CPU_CYCLE,
    output var  logic                    O_CPU_RUN
);
    logic                      main_tick_raw;
    logic                      main_tick;
    logic                      sub_tick;
    logic [CHAIN_W-1:0]        chain_reg;
    logic [STAB_WAIT_LOG2:0]   stab_cnt_reg;
    logic                      main_stable;
    logic [1:0]                sub_phase_reg;
    logic                      cpu_cycle_now;
    logic                      main_ground;
    logic [1:0]                cpu_div_reg;
    logic [1:0]                cpu_div_next;
    logic [3:0]                sys_clk_reg;
    logic [3:0]                sys_clk_next;
    logic [3:0]                subosc_reg;
    logic [3:0]                subosc_next;
    scs_clk_sel_type           active_reg;
    scs_clk_sel_type           sel_next;
    scs_sw_state_type          sw_state_reg;
    logic [LAT_W-1:0]          lat_cnt_reg;
    logic                      swap_now;
    logic                      aw_have_reg;
    logic                      w_have_reg;
    logic [AXI_ADDR_W-1:0]     aw_addr_reg;
    logic [AXI_DATA_W-1:0]     w_data_reg;
    logic [AXI_DATA_W/8-1:0]   w_strb_reg;
    logic                      wr_fire;
    logic [AXI_ADDR_W-1:0]     wr_ofs;
    logic [AXI_ADDR_W-1:0]     rd_ofs;
    logic                      wr_mapped;
    logic [AXI_DATA_W-1:0]     rd_data;
    logic                      rd_mapped;
    logic                      sel_write;

    scs_tick_sync u_main_sync
    (
        .I_CLK   (I_CLK),
        .I_RST_N (I_RST_N),
        .i_pin   (I_MAIN_OSC_IN),
        .o_tick  (main_tick_raw)
    );

    scs_tick_sync u_sub_sync
    (
        .I_CLK   (I_CLK),
        .I_RST_N (I_RST_N),
        .i_pin   (I_SUB_OSC_IN),
        .o_tick  (sub_tick)
    );

    // Edges seen while the oscillator is held off are leakage, not clock
    assign main_tick   = main_tick_raw & O_MAIN_OSC_EN;
    assign main_stable = stab_cnt_reg[STAB_WAIT_LOG2];
    assign main_ground = I_STOP_MODE | (sys_clk_reg[SCC_STOP_BIT] & active_reg.sub);

    always_ff @(posedge I_CLK)
    begin
        if (!I_RST_N)
        begin
            O_MAIN_OSC_EN    <= 1'b1;
            O_MAIN_IN_GROUND <= 1'b0;
        end
        else
        begin
            O_MAIN_IN_GROUND <= main_ground;
            O_MAIN_OSC_EN    <= ~main_ground;
        end
    end

    always_ff @(posedge I_CLK)
    begin
        if (!I_RST_N)
            chain_reg <= '0;
        else if (main_tick)
            chain_reg <= chain_reg + 1'b1;
    end

    // Restarted after every oscillator stop, so a cold crystal never clocks the CPU
    always_ff @(posedge I_CLK)
    begin
        if (!I_RST_N || !O_MAIN_OSC_EN)
            stab_cnt_reg <= '0;
        else if (main_tick && !main_stable)
            stab_cnt_reg <= stab_cnt_reg + 1'b1;
    end

    always_ff @(posedge I_CLK)
    begin
        if (!I_RST_N)
            O_CPU_RUN <= 1'b0;
        else if (main_stable)
            O_CPU_RUN <= 1'b1;
    end

    always_comb
    begin
        if (active_reg.sub)
            cpu_cycle_now = sub_tick && (sub_phase_reg == SUB_PHASE_END);
        else
            cpu_cycle_now = main_tick && main_stable && O_CPU_RUN &&
                ((chain_reg & scs_cycle_mask(active_reg.div)) ==
                 scs_cycle_mask(active_reg.div));
        // A cycle right behind the swap cycle would be a one-clock runt
        if (O_CPU_CYCLE)
            cpu_cycle_now = 1'b0;
    end

    always_ff @(posedge I_CLK)
    begin
        if (!I_RST_N)
            O_CPU_CYCLE <= 1'b0;
        else
            O_CPU_CYCLE <= cpu_cycle_now;
    end

    // Phase cleared on entry so the first sub cycle is full length
    always_ff @(posedge I_CLK)
    begin
        if (!I_RST_N)
            sub_phase_reg <= '0;
        else if (swap_now && sel_next.sub && !active_reg.sub)
            sub_phase_reg <= '0;
        else if (sub_tick)
            sub_phase_reg <= sub_phase_reg + 1'b1;
    end

    assign wr_fire   = aw_have_reg && w_have_reg && !O_S_AXI_BVALID;
    assign wr_ofs    = {aw_addr_reg[AXI_ADDR_W-1:2], 2'b00};
    assign rd_ofs    = {I_S_AXI_ARADDR[AXI_ADDR_W-1:2], 2'b00};
    assign wr_mapped = (wr_ofs == OFS_CPU_DIV) || (wr_ofs == OFS_SYS_CLK) ||
                       (wr_ofs == OFS_SUBOSC) || (wr_ofs == OFS_STATUS);
    assign sel_write = wr_fire && w_strb_reg[0] &&
                       ((wr_ofs == OFS_CPU_DIV) || (wr_ofs == OFS_SYS_CLK));

    always_comb
    begin
        cpu_div_next = cpu_div_reg;
        sys_clk_next = sys_clk_reg;
        subosc_next  = subosc_reg;
        if (wr_fire && w_strb_reg[0])
        begin
            if (wr_ofs == OFS_CPU_DIV)
                cpu_div_next = w_data_reg[1:0];
            if (wr_ofs == OFS_SYS_CLK)
            begin
                sys_clk_next[SCC_SUB_BIT]  = w_data_reg[SCC_SUB_BIT];
                sys_clk_next[SCC_STOP_BIT] = w_data_reg[SCC_STOP_BIT];
            end
            if (wr_ofs == OFS_SUBOSC)
                subosc_next = w_data_reg[3:0];
        end
        sel_next.sub = sys_clk_next[SCC_SUB_BIT];
        sel_next.div = cpu_div_next;
    end

    always_ff @(posedge I_CLK)
    begin
        if (!I_RST_N)
        begin
            cpu_div_reg <= CPU_DIV_RESET;
            sys_clk_reg <= SYS_CLK_RESET;
            subosc_reg  <= SUBOSC_RESET;
        end
        else
        begin
            cpu_div_reg <= cpu_div_next;
            sys_clk_reg <= sys_clk_next;
            subosc_reg  <= subosc_next;
        end
    end

    always_ff @(posedge I_CLK)
    begin
        if (!I_RST_N)
        begin
            O_SUB_FEEDBACK_CUT <= 1'b0;
            O_SUB_LOW_DRIVE    <= 1'b0;
        end
        else
        begin
            O_SUB_FEEDBACK_CUT <= subosc_reg[SOS_CUT_BIT];
            O_SUB_LOW_DRIVE    <= subosc_reg[SOS_LOW_BIT];
        end
    end

    assign swap_now = (sw_state_reg == SW_WAIT) && !sel_write && cpu_cycle_now &&
                      (lat_cnt_reg == LAT_FROM_SUB);

    // Swapping only on a machine cycle edge keeps the CPU clock free of runt cycles
    always_ff @(posedge I_CLK)
    begin
        if (!I_RST_N)
        begin
            sw_state_reg    <= SW_IDLE;
            lat_cnt_reg     <= '0;
            active_reg.sub  <= 1'b0;
            active_reg.div  <= CPU_DIV_RESET;
        end
        else if (sel_write)
        begin
            if (sel_next != active_reg)
            begin
                sw_state_reg <= SW_WAIT;
                lat_cnt_reg  <= scs_switch_latency(active_reg, sel_next);
            end
            else
                sw_state_reg <= SW_IDLE;
        end
        else
        begin
            unique case (sw_state_reg)
                SW_IDLE: lat_cnt_reg <= lat_cnt_reg;
                SW_WAIT:
                begin
                    if (swap_now)
                    begin
                        active_reg   <= sel_next;
                        sw_state_reg <= SW_IDLE;
                    end
                    else if (cpu_cycle_now)
                        lat_cnt_reg <= lat_cnt_reg - 1'b1;
                end
                default: sw_state_reg <= SW_IDLE;
            endcase
        end
    end

    always_ff @(posedge I_CLK)
    begin
        if (!I_RST_N)
        begin
            aw_have_reg     <= 1'b0;
            w_have_reg      <= 1'b0;
            aw_addr_reg     <= '0;
            w_data_reg      <= '0;
            w_strb_reg      <= '0;
            O_S_AXI_AWREADY <= 1'b0;
            O_S_AXI_WREADY  <= 1'b0;
            O_S_AXI_BVALID  <= 1'b0;
            O_S_AXI_BRESP   <= RESP_OKAY;
        end
        else
        begin
            if (O_S_AXI_AWREADY && I_S_AXI_AWVALID)
            begin
                aw_have_reg     <= 1'b1;
                aw_addr_reg     <= I_S_AXI_AWADDR;
                O_S_AXI_AWREADY <= 1'b0;
            end
            else if (!aw_have_reg && !O_S_AXI_BVALID)
                O_S_AXI_AWREADY <= 1'b1;
            if (O_S_AXI_WREADY && I_S_AXI_WVALID)
            begin
                w_have_reg     <= 1'b1;
                w_data_reg     <= I_S_AXI_WDATA;
                w_strb_reg     <= I_S_AXI_WSTRB;
                O_S_AXI_WREADY <= 1'b0;
            end
            else if (!w_have_reg && !O_S_AXI_BVALID)
                O_S_AXI_WREADY <= 1'b1;
            if (wr_fire)
            begin
                aw_have_reg    <= 1'b0;
                w_have_reg     <= 1'b0;
                O_S_AXI_BVALID <= 1'b1;
                O_S_AXI_BRESP  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
            end
            else if (O_S_AXI_BVALID && I_S_AXI_BREADY)
                O_S_AXI_BVALID <= 1'b0;
        end
    end

    always_comb
    begin
        rd_data   = '0;
        rd_mapped = 1'b1;
        unique case (rd_ofs)
            OFS_CPU_DIV: rd_data[1:0] = cpu_div_reg;
            OFS_SYS_CLK: rd_data[3:0] = sys_clk_reg;
            OFS_SUBOSC:  rd_data[3:0] = subosc_reg;
            OFS_STATUS:
            begin
                rd_data[ST_SUB_BIT]              = active_reg.sub;
                rd_data[ST_DIV_LSB+1:ST_DIV_LSB] = active_reg.div;
                rd_data[ST_PEND_BIT]             = (sw_state_reg == SW_WAIT);
                rd_data[ST_STABLE_BIT]           = main_stable;
                rd_data[ST_RUN_BIT]              = O_CPU_RUN;
                rd_data[ST_OSC_BIT]              = O_MAIN_OSC_EN;
            end
            default: rd_mapped = 1'b0;
        endcase
    end

    always_ff @(posedge I_CLK)
    begin
        if (!I_RST_N)
        begin
            O_S_AXI_ARREADY <= 1'b0;
            O_S_AXI_RVALID  <= 1'b0;
            O_S_AXI_RDATA   <= '0;
            O_S_AXI_RRESP   <= RESP_OKAY;
        end
        else if (O_S_AXI_ARREADY && I_S_AXI_ARVALID)
        begin
            O_S_AXI_ARREADY <= 1'b0;
            O_S_AXI_RVALID  <= 1'b1;
            O_S_AXI_RDATA   <= rd_data;
            O_S_AXI_RRESP   <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
        end
        else if (O_S_AXI_RVALID && I_S_AXI_RREADY)
            O_S_AXI_RVALID <= 1'b0;
        else if (!O_S_AXI_RVALID)
            O_S_AXI_ARREADY <= 1'b1;
    end

    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_RST_N);

    AST_GROUND_IN_STOP: assert property (I_STOP_MODE |=> O_MAIN_IN_GROUND && !O_MAIN_OSC_EN)
        else $error("main input not grounded in stop mode");
    AST_CYCLE_FROM_CHAIN: assert property ((cpu_cycle_now && !active_reg.sub) |->
        main_tick && ((chain_reg & scs_cycle_mask(active_reg.div)) == scs_cycle_mask(active_reg.div)))
        else $error("main machine cycle off the divider chain");
    AST_SUBOSC_RESET: assert property (@(posedge I_CLK) disable iff (1'b0)
        !I_RST_N |=> (subosc_reg == SUBOSC_RESET) && !O_SUB_FEEDBACK_CUT)
        else $error("sub oscillator control not cleared by reset");
    AST_FEEDBACK_CUT: assert property ($changed(subosc_reg[SOS_CUT_BIT]) |=>
        O_SUB_FEEDBACK_CUT == $past(subosc_reg[SOS_CUT_BIT]))
        else $error("feedback cut output does not follow its flag");
    AST_LOW_DRIVE: assert property (subosc_reg[SOS_LOW_BIT] [*2] |-> O_SUB_LOW_DRIVE)
        else $error("low drive output does not follow its flag");
    AST_NO_EARLY_SWAP: assert property ((sw_state_reg == SW_WAIT && lat_cnt_reg > LAT_FROM_SUB)
        |=> $stable(active_reg))
        else $error("clock selection swapped before latency expired");
    AST_SUB_LATENCY: assert property ((sel_write && sel_next.sub && !active_reg.sub) |=>
        lat_cnt_reg == (($past(active_reg.div) == DIV_64) ? LAT_W'(LAT_SUB_64) :
                        ($past(active_reg.div) == DIV_16) ? LAT_W'(LAT_SUB_16) :
                        ($past(active_reg.div) == DIV_8)  ? LAT_W'(LAT_SUB_8)  :
                                                            LAT_W'(LAT_SUB_4)))
        else $error("main to sub latency loaded wrong");
    AST_CYCLE_OUT: assert property (cpu_cycle_now |=> O_CPU_CYCLE ##1 !O_CPU_CYCLE)
        else $error("machine cycle output is not a one-cycle pulse");
    AST_WAIT_STABLE: assert property ((!main_stable && !active_reg.sub) |-> !cpu_cycle_now)
        else $error("CPU clocked before oscillation stabilised");
    AST_SYSCLK_RESET: assert property (@(posedge I_CLK) disable iff (1'b0)
        !I_RST_N |=> sys_clk_reg == SYS_CLK_RESET && !active_reg.sub)
        else $error("system clock control not cleared by reset");
    AST_STOP_ONLY_SUB: assert property ((!active_reg.sub && !I_STOP_MODE) |=> O_MAIN_OSC_EN)
        else $error("main oscillator stopped while running from main");
    AST_SWAP_ON_CYCLE: assert property ($changed(active_reg) |-> $past(cpu_cycle_now))
        else $error("clock swap off a machine cycle boundary");

    COV_TO_SUB: cover property (swap_now && sel_next.sub && !active_reg.sub);
    COV_DIV_CHANGE: cover property (swap_now && !sel_next.sub && !active_reg.sub);
    COV_MAIN_STOPPED: cover property (active_reg.sub && !O_MAIN_OSC_EN);
    COV_CPU_START: cover property ($rose(O_CPU_RUN));
endmodule : scs_top
`default_nettype wire

// ==== shared/scs_pkg.sv ====
// Constants, types and helpers for the system clock selection block
`default_nettype none
package scs_pkg;
    localparam int         MAIN_OSC_HZ   = 6000000;
    localparam int         SUB_OSC_HZ    = 32768;
    localparam int         AXI_ADDR_W    = 4;
    localparam int         AXI_DATA_W    = 32;
    localparam logic [3:0] OFS_CPU_DIV   = 4'h0;
    localparam logic [3:0] OFS_SYS_CLK   = 4'h4;
    localparam logic [3:0] OFS_SUBOSC    = 4'h8;
    localparam logic [3:0] OFS_STATUS    = 4'hC;
    localparam logic [1:0] RESP_OKAY     = 2'h0;
    localparam logic [1:0] RESP_SLVERR   = 2'h2;
    localparam logic [1:0] DIV_64        = 2'h0;
    localparam logic [1:0] DIV_16        = 2'h1;
    localparam logic [1:0] DIV_8         = 2'h2;
    localparam logic [1:0] DIV_4         = 2'h3;
    localparam logic [1:0] CPU_DIV_RESET = 2'h0;
    localparam logic [3:0] SYS_CLK_RESET = 4'h0;
    localparam logic [3:0] SUBOSC_RESET  = 4'h0;
    localparam int         SCC_SUB_BIT   = 0;
    localparam int         SCC_STOP_BIT  = 3;
    localparam int         SOS_CUT_BIT   = 0;
    localparam int         SOS_LOW_BIT   = 1;
    localparam int         ST_SUB_BIT    = 0;
    localparam int         ST_DIV_LSB    = 1;
    localparam int         ST_PEND_BIT   = 3;
    localparam int         ST_STABLE_BIT = 4;
    localparam int         ST_RUN_BIT    = 5;
    localparam int         ST_OSC_BIT    = 6;
    localparam int         CHAIN_W       = 6;
    localparam int         LAT_W         = 8;
    localparam logic [1:0] SUB_PHASE_END = 2'h3;
    localparam int         STAB_LOG2     = 15;
    localparam logic [LAT_W-1:0] LAT_FROM_SUB  = 8'h01;
    localparam logic [LAT_W-1:0] LAT_MAIN_64   = 8'h01;
    localparam logic [LAT_W-1:0] LAT_MAIN_16   = 8'h04;
    localparam logic [LAT_W-1:0] LAT_MAIN_8    = 8'h08;
    localparam logic [LAT_W-1:0] LAT_MAIN_4    = 8'h10;
    // Rounded to nearest: 3, 11, 23, 46 machine cycles at the nominal rates
    localparam int LAT_SUB_64 = (MAIN_OSC_HZ + 32 * SUB_OSC_HZ) / (64 * SUB_OSC_HZ);
    localparam int LAT_SUB_16 = (MAIN_OSC_HZ + 8 * SUB_OSC_HZ) / (16 * SUB_OSC_HZ);
    localparam int LAT_SUB_8  = (MAIN_OSC_HZ + 4 * SUB_OSC_HZ) / (8 * SUB_OSC_HZ);
    localparam int LAT_SUB_4  = (MAIN_OSC_HZ + 2 * SUB_OSC_HZ) / (4 * SUB_OSC_HZ);

    typedef struct packed {
        logic       sub;
        logic [1:0] div;
    } scs_clk_sel_type;

    typedef enum logic [1:0] {
        SW_IDLE = 2'b01,
        SW_WAIT = 2'b10
    } scs_sw_state_type;

    function automatic logic [LAT_W-1:0] scs_switch_latency(input scs_clk_sel_type from_sel,
                                                            input scs_clk_sel_type to_sel);
        logic [LAT_W-1:0] lat;
        lat = LAT_FROM_SUB;
        if (!from_sel.sub && to_sel.sub)
        begin
            unique case (from_sel.div)
                DIV_64: lat = LAT_W'(LAT_SUB_64);
                DIV_16: lat = LAT_W'(LAT_SUB_16);
                DIV_8:  lat = LAT_W'(LAT_SUB_8);
                DIV_4:  lat = LAT_W'(LAT_SUB_4);
            endcase
        end
        else if (!from_sel.sub)
        begin
            unique case (from_sel.div)
                DIV_64: lat = LAT_MAIN_64;
                DIV_16: lat = LAT_MAIN_16;
                DIV_8:  lat = LAT_MAIN_8;
                DIV_4:  lat = LAT_MAIN_4;
            endcase
        end
        return lat;
    endfunction : scs_switch_latency

    function automatic logic [CHAIN_W-1:0] scs_cycle_mask(input logic [1:0] div);
        logic [CHAIN_W-1:0] mask;
        mask = 6'h3F;
        unique case (div)
            DIV_64: mask = 6'h3F;
            DIV_16: mask = 6'h0F;
            DIV_8:  mask = 6'h07;
            DIV_4:  mask = 6'h03;
        endcase
        return mask;
    endfunction : scs_cycle_mask
endpackage : scs_pkg
`default_nettype wire

// ==== hdl/scs_tick_sync.sv ====
// Pin synchroniser that turns oscillator rising edges into one-cycle ticks
`default_nettype none
module scs_tick_sync
(
    input  wire logic I_CLK,
    input  wire logic I_RST_N,
    input  wire logic i_pin,
    output var  logic o_tick
);
    logic sync1_reg;
    logic sync2_reg;
    logic prev_reg;

    always_ff @(posedge I_CLK)
    begin
        if (!I_RST_N)
        begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
            prev_reg  <= 1'b0;
            o_tick    <= 1'b0;
        end
        else
        begin
            sync1_reg <= i_pin;
            sync2_reg <= sync1_reg;
            prev_reg  <= sync2_reg;
            o_tick    <= sync2_reg & ~prev_reg;
        end
    end
endmodule : scs_tick_sync
`default_nettype wire

// ==== tb/system_clock_selection_test.sv ====
// Self-checking bench for the system clock selection block
`default_nettype none
module system_clock_selection_test
    import scs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, rst_n = 0, mosc = 0, sosc = 0, stp = 0;
    logic awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
    logic [3:0] awa = '0, ara = '0, ws = '0;
    logic [31:0] wd = '0, rd, r;
    logic [1:0] bresp, rresp;
    logic awr, wrd, bv, arr, rv, en, gnd, fbc, lod, cyc, run;
    logic [31:0] rq[$];
    logic [1:0] bq[$];
    int mismatches = 0, compares = 0, n, t = 0;
    scs_top #(.STAB_WAIT_LOG2(4)) u_scs_top (
        .I_CLK(clk), .I_RST_N(rst_n), .I_MAIN_OSC_IN(mosc), .I_SUB_OSC_IN(sosc),
        .I_STOP_MODE(stp), .I_S_AXI_AWADDR(awa), .I_S_AXI_AWVALID(awv),
        .O_S_AXI_AWREADY(awr), .I_S_AXI_WDATA(wd), .I_S_AXI_WSTRB(ws),
        .I_S_AXI_WVALID(wv), .O_S_AXI_WREADY(wrd), .O_S_AXI_BRESP(bresp),
        .O_S_AXI_BVALID(bv), .I_S_AXI_BREADY(br), .I_S_AXI_ARADDR(ara),
        .I_S_AXI_ARVALID(arv), .O_S_AXI_ARREADY(arr), .O_S_AXI_RDATA(rd),
        .O_S_AXI_RRESP(rresp), .O_S_AXI_RVALID(rv), .I_S_AXI_RREADY(rr),
        .O_MAIN_OSC_EN(en), .O_MAIN_IN_GROUND(gnd), .O_SUB_FEEDBACK_CUT(fbc),
        .O_SUB_LOW_DRIVE(lod), .O_CPU_CYCLE(cyc), .O_CPU_RUN(run));
    initial
    begin
        forever #12.5 clk = ~clk;
    end
    // Main tick every 8 cycles, silent while disabled; sub tick every 50
    always @(posedge clk)
    begin
        t <= t + 1;
        mosc <= en && (t % 8) < 4;
        sosc <= (t % 50) < 25;
    end
    task automatic chk(string nm, logic [33:0] e, logic [33:0] g);
        compares++;
        if (g !== e)
        begin
            mismatches++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask : chk
    // Registered outputs are steady at the falling edge, so sample there
    always @(negedge clk)
    begin
        if (rv && rr && rq.size() > 0)
            chk("read", {RESP_OKAY, rq.pop_front()}, {rresp, rd});
        if (bv && br && bq.size() > 0)
            chk("bresp", bq.pop_front(), bresp);
    end
    task automatic final_report;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : final_report
    task automatic tmo(int k);
        if (k <= 0)
        begin
            mismatches++;
            final_report();
        end
    endtask : tmo
    task automatic wr(logic [3:0] a, logic [31:0] d);
        int k;
        logic ha, hw, hb;
        k = 200;
        bq.push_back(RESP_OKAY);
        awa <= a;
        wd <= d;
        ws <= 4'hF;
        awv <= 1;
        wv <= 1;
        br <= 1;
        do
        begin
            @(negedge clk);
            ha = awr;
            hw = wrd;
            hb = bv;
            @(posedge clk);
            if (ha)
                awv <= 0;
            if (hw)
                wv <= 0;
            k--;
        end while (!hb && k > 0);
        br <= 0;
        tmo(k);
    endtask : wr
    task automatic rdc(logic [3:0] a, logic [31:0] e);
        int k;
        logic h, g;
        k = 200;
        rq.push_back(e);
        ara <= a;
        arv <= 1;
        rr <= 1;
        do
        begin
            @(negedge clk);
            h = arr;
            g = rv;
            @(posedge clk);
            if (h)
                arv <= 0;
            k--;
        end while (!g && k > 0);
        rr <= 0;
        tmo(k);
    endtask : rdc
    task automatic per(output int p);
        int k;
        k = 3000;
        p = 0;
        do
        begin
            @(negedge clk);
            k--;
        end while (!cyc && k > 0);
        tmo(k);
        do
        begin
            @(negedge clk);
            p++;
        end while (!cyc && p < 3000);
        @(posedge clk);
    endtask : per
    initial
    begin
        void'($urandom(29));
        repeat (16) @(posedge clk);
        rst_n <= 1;
        @(posedge clk);
        chk("pins", 3'b100, {en, gnd, run});
        rdc(OFS_CPU_DIV, 0);
        rdc(OFS_SYS_CLK, 0);
        rdc(OFS_SUBOSC, 0);
        per(n);
        chk("run", 1, run);
        chk("per64", 512, n);
        r = $urandom;
        wr(OFS_CPU_DIV, {r[31:2], DIV_4});
        rdc(OFS_STATUS, 32'h78);
        per(n);
        per(n);
        chk("per4", 32, n);
        wr(OFS_SYS_CLK, 8);
        repeat (4) @(posedge clk);
        chk("nostop", 2'b10, {en, gnd});
        wr(OFS_SYS_CLK, 1);
        repeat (1280) @(posedge clk);
        rdc(OFS_STATUS, 32'h7E);
        repeat (320) @(posedge clk);
        rdc(OFS_STATUS, 32'h77);
        rdc(OFS_CPU_DIV, 3);
        per(n);
        chk("persub", 200, n);
        wr(OFS_SYS_CLK, 9);
        repeat (4) @(posedge clk);
        chk("stop", 2'b01, {en, gnd});
        wr(OFS_SUBOSC, 1);
        repeat (2) @(posedge clk);
        chk("sos", 2'b10, {fbc, lod});
        wr(OFS_SUBOSC, 2);
        repeat (2) @(posedge clk);
        chk("sos", 2'b01, {fbc, lod});
        rdc(OFS_SUBOSC, 2);
        wr(OFS_SYS_CLK, 1);
        repeat (400) @(posedge clk);
        chk("restart", 2'b10, {en, gnd});
        wr(OFS_SYS_CLK, 0);
        repeat (400) @(posedge clk);
        rdc(OFS_STATUS, 32'h76);
        stp <= 1;
        repeat (4) @(posedge clk);
        chk("stopmode", 2'b01, {en, gnd});
        stp <= 0;
        wr(OFS_STATUS, 32'hFF);
        final_report();
    end
endmodule : system_clock_selection_test
`default_nettype wire
